// ### rtl/ssfs_selector.sv
// Notes on behaviour
// - Candidates ranked video 1, video 2, AES3, word clock, internal 48 kHz.
// - Failed or absent selected source falls over to next ranked candidate.
// - Output 48 kHz tick from selected input; usable only if 48 kHz derivable.
// - Video reference edges divided down to the 48 kHz audio tick.
// - Input held valid only while within 100 ppm of nominal.
// - Four external sync inputs plus the internal clock as an option.
// - Internal reference only from the currently active router card.
// - Video ports interchangeable; analog or tri-level set by configuration.
// - Five options mapped to rank positions by configuration settings.
`timescale 1ns/1ps
`default_nettype none

module ssfs_selector
   import ssfs_pkg::*;
#(
   parameter logic [DIV_W-1:0] VID_SD_DIV = 16'h0001,
   parameter logic [DIV_W-1:0] VID_TRI_DIV = 16'h0001,
   parameter logic [CNT_W-1:0] WIN_NOM = CNT_W'(WIN_NOM_CYC),
   parameter logic [CNT_W-1:0] WIN_TOL = CNT_W'(WIN_TOL_CYC),
   parameter logic [CNT_W-1:0] LOSS_LIM = CNT_W'(LOSS_CYC)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Sync pins and router state
   input wire logic [NEXT-1:0] sync_i,
   input wire logic router_active_i,
   // Configuration
   input wire ssfs_cfg_t cfg_i,
   // Reference out and status
   output logic tick48_o,
   output logic fail_o,
   output ssfs_stat_t stat_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [NEXT:0] meta_ff;
   logic [NEXT:0] sync_ff;
   logic [NEXT-1:0] prev_ff;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= {router_active_i, sync_i};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff[NEXT-1:0];
      end
   end

   wire [NEXT-1:0] rise = sync_ff[NEXT-1:0] & ~prev_ff;
   wire router_active = sync_ff[NEXT];

   logic [NSRC-1:0] tick;
   logic [NSRC-1:0] valid;

   // ----------------------------------------------------------------
   // External source dividers and monitors
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NEXT; g++) begin : g_mon
         logic [DIV_W-1:0] pre_ff;
         logic tick_ff;
         logic [CNT_W-1:0] gap_ff;
         logic [CNT_W-1:0] win_ff;
         logic [9:0] nt_ff;
         logic valid_ff;
         wire [DIV_W-1:0] div;
         wire pre_end;
         wire win_end;
         wire in_tol;
         wire lost;

         if (g < 2) begin : g_vid
            assign div = cfg_i.vid_tri[g] ? VID_TRI_DIV : VID_SD_DIV;
         end else begin : g_dig
            assign div = DIV_W'(1);
         end

         assign pre_end = rise[g] && (pre_ff >= div - DIV_W'(1));
         assign win_end = tick_ff && (nt_ff == 10'(WIN_TICKS - 1));
         assign in_tol = (win_ff >= WIN_NOM - WIN_TOL) &&
                         (win_ff <= WIN_NOM + WIN_TOL);
         // No derived tick for too long drops the source at once
         assign lost = gap_ff >= LOSS_LIM;

         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               pre_ff <= '0;
               tick_ff <= 1'b0;
            end else begin
               tick_ff <= pre_end;
               if (pre_end) begin
                  pre_ff <= '0;
               end else if (rise[g]) begin
                  pre_ff <= pre_ff + DIV_W'(1);
               end
            end
         end

         // Window over derived ticks, measured in system clocks
         always_ff @(posedge clk_i) begin
            if (reset_i || lost) begin
               gap_ff <= '0;
               win_ff <= '0;
               nt_ff <= '0;
               valid_ff <= 1'b0;
            end else begin
               gap_ff <= tick_ff ? '0 : gap_ff + CNT_W'(1);
               if (win_ff != {CNT_W{1'b1}}) begin
                  win_ff <= win_ff + CNT_W'(1);
               end
               if (tick_ff) begin
                  nt_ff <= nt_ff + 10'h001;
               end
               if (win_end) begin
                  win_ff <= '0;
                  valid_ff <= in_tol;
               end
            end
         end

         assign tick[g] = tick_ff;
         assign valid[g] = valid_ff && !lost;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Internal 48 kHz reference, active router card only
   // ----------------------------------------------------------------
   logic [31:0] nco_ff;
   logic int_tick_ff;
   // Phase accumulator steps by the reference rate, wraps at clock rate
   wire [32:0] nco_sum = {1'b0, nco_ff} + 33'(REF_HZ);
   wire nco_wrap = nco_sum >= 33'(CLK_HZ);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         nco_ff <= '0;
         int_tick_ff <= 1'b0;
      end else begin
         nco_ff <= nco_wrap ? 32'(nco_sum - 33'(CLK_HZ)) : nco_sum[31:0];
         int_tick_ff <= nco_wrap && router_active;
      end
   end

   // Internal reference is not measured; trusted while card is active
   assign tick[SRC_INT] = int_tick_ff;
   assign valid[SRC_INT] = router_active;

   // ----------------------------------------------------------------
   // Ranked selection
   // ----------------------------------------------------------------
   function automatic logic [SRC_W-1:0] src_at(input ssfs_cfg_t c,
                                               input int r);
      src_at = c.prio[r];
   endfunction

   logic [SRC_W-1:0] pick_rank;
   logic pick_ok;

   // Lowest rank number holding a valid source wins
   always_comb begin
      pick_rank = '0;
      pick_ok = 1'b0;
      for (int r = NSRC - 1; r >= 0; r--) begin
         if (src_at(cfg_i, r) < SRC_W'(NSRC) &&
             valid[src_at(cfg_i, r)]) begin
            pick_rank = SRC_W'(r);
            pick_ok = 1'b1;
         end
      end
   end

   wire [SRC_W-1:0] pick_src = src_at(cfg_i, int'(pick_rank));

   logic locked_ff;
   logic [SRC_W-1:0] rank_ff;
   logic [SRC_W-1:0] src_ff;
   logic fail_ff;
   logic tick_out_ff;

   wire drop = locked_ff && (!pick_ok || pick_rank > rank_ff);

   // ----------------------------------------------------------------
   // Output tick guard
   // ----------------------------------------------------------------
   // A source change can line up two derived ticks back to back;
   // the second is held back so the output pulse never runs wide.
   wire src_change = pick_src != src_ff;
   wire tick_hold = tick_out_ff && src_change;
   wire tick_pick = pick_ok && tick[pick_src] && !tick_hold;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         locked_ff <= 1'b0;
         rank_ff <= '0;
         src_ff <= SRC_INT;
         fail_ff <= 1'b0;
         tick_out_ff <= 1'b0;
      end else begin
         locked_ff <= pick_ok;
         rank_ff <= pick_rank;
         src_ff <= pick_src;
         fail_ff <= drop;
         tick_out_ff <= tick_pick;
      end
   end

   assign tick48_o = tick_out_ff;
   assign fail_o = fail_ff;
   assign stat_o = '{locked: locked_ff, src: src_ff, rank: rank_ff,
                     avail: valid};

endmodule

`default_nettype wire

// ### pkg/ssfs_pkg.sv
package ssfs_pkg;

   // ----------------------------------------------------------------
   // Clock and reference rates
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 100_000_000;
   localparam longint REF_HZ = 48_000;
   localparam longint TOL_PPM = 100;
   localparam longint PPM_DEN = 1_000_000;

   // ----------------------------------------------------------------
   // Measurement timing
   // ----------------------------------------------------------------
   localparam longint WIN_TICKS = 1024;
   localparam longint WIN_NOM_CYC = WIN_TICKS * CLK_HZ / REF_HZ;
   localparam longint WIN_TOL_CYC = WIN_NOM_CYC * TOL_PPM / PPM_DEN;
   localparam longint TICK_NOM_CYC = CLK_HZ / REF_HZ;
   localparam longint LOSS_CYC = 2 * TICK_NOM_CYC;
   localparam int CNT_W = 24;
   localparam int DIV_W = 16;

   // ----------------------------------------------------------------
   // Source codes and default ranking
   // ----------------------------------------------------------------
   localparam int NEXT = 4;
   localparam int NSRC = 5;
   localparam int SRC_W = 3;
   localparam logic [2:0] SRC_VID1 = 3'h0;
   localparam logic [2:0] SRC_VID2 = 3'h1;
   localparam logic [2:0] SRC_AES = 3'h2;
   localparam logic [2:0] SRC_WCLK = 3'h3;
   localparam logic [2:0] SRC_INT = 3'h4;
   localparam logic [14:0] PRIO_DEFAULT =
      {SRC_INT, SRC_WCLK, SRC_AES, SRC_VID2, SRC_VID1};

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NSRC-1:0][SRC_W-1:0] prio;
      logic [1:0] vid_tri;
   } ssfs_cfg_t;

   typedef struct packed {
      logic locked;
      logic [SRC_W-1:0] src;
      logic [SRC_W-1:0] rank;
      logic [NSRC-1:0] avail;
   } ssfs_stat_t;

endpackage

// ### tb/ssfs_selector_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssfs_selector_chk
   import ssfs_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Watched ports
   input wire ssfs_cfg_t cfg_i,
   input wire logic tick48_o,
   input wire logic fail_o,
   input wire ssfs_stat_t stat_o
);
   // Selection inputs one cycle back
   logic [NSRC-1:0][SRC_W-1:0] prio_ff;
   logic [NSRC-1:0] avail_ff;
   always_ff @(posedge clk_i) begin
      prio_ff <= cfg_i.prio;
      avail_ff <= stat_o.avail;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   AST_FAIL_PULSE: assert property (fail_o |=> !fail_o)
      else $error("fail pulse too long");
   AST_FAIL_CAUSE: assert property (fail_o |->
      $past(stat_o.locked) && (!stat_o.locked ||
      stat_o.rank > $past(stat_o.rank))) else $error("fail without drop");
   AST_DROP_FLAGGED: assert property (stat_o.locked &&
      $past(stat_o.locked) && stat_o.rank > $past(stat_o.rank) |-> fail_o)
      else $error("drop not flagged");
   AST_SRC_VALID: assert property (stat_o.locked |->
      avail_ff[stat_o.src]) else $error("invalid source selected");
   AST_PRIO_MAP: assert property (stat_o.locked |->
      prio_ff[stat_o.rank] == stat_o.src) else $error("rank and source differ");
   AST_LOCK_ANY: assert property (|avail_ff |-> stat_o.locked)
      else $error("valid source left unused");
   AST_TICK_ONE: assert property (tick48_o |=> !tick48_o)
      else $error("tick longer than a cycle");
   AST_TICK_GATED: assert property (!stat_o.locked &&
      $past(!stat_o.locked) |-> !tick48_o) else $error("tick while unlocked");
   cover property (fail_o);
   cover property (tick48_o && stat_o.src != SRC_INT);
   cover property (stat_o.locked && stat_o.src == SRC_INT);
endmodule
bind ssfs_selector ssfs_selector_chk ssfs_selector_chk_inst (.clk_i(clk_i),
   .reset_i(reset_i), .cfg_i(cfg_i), .tick48_o(tick48_o), .fail_o(fail_o),
   .stat_o(stat_o));
`default_nettype wire

// ### tb/ssfs_sync_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ssfs_sync_gen
   import ssfs_pkg::*;
#(
   parameter int PER [NEXT] = '{20, 20, 20, 20}
) (
   // Clock
   input wire logic clk_i,
   // Source enables and sync lines
   input wire logic [NEXT-1:0] en_i,
   output logic [NEXT-1:0] sync_o
);
   int cnt_ff [NEXT];
   // Terminated line: a dropped source reads low
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NEXT; i++) begin
         cnt_ff[i] <= (cnt_ff[i] >= PER[i] - 1) ? 0 : cnt_ff[i] + 1;
         sync_o[i] <= en_i[i] && (cnt_ff[i] < PER[i] / 2);
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_sync_source_failover_selector.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sync_source_failover_selector
   import ssfs_pkg::*;
;
   typedef struct packed {logic [3:0] en; logic [14:0] prio;
      logic [2:0] src, rank;} ssfs_row_t;
   ssfs_row_t rows [5] = '{
      '{4'hF, {SRC_INT, SRC_VID2, SRC_AES, SRC_VID1, SRC_WCLK}, SRC_WCLK, 3'h0},
      '{4'hF, PRIO_DEFAULT, SRC_VID1, 3'h0},
      '{4'hE, PRIO_DEFAULT, SRC_VID2, 3'h1},
      '{4'hC, PRIO_DEFAULT, SRC_WCLK, 3'h3},
      '{4'h4, PRIO_DEFAULT, SRC_INT, 3'h4}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic act = 1'b1;
   logic [3:0] en = 4'hF;
   logic [3:0] sync;
   ssfs_cfg_t cfg = '{prio: PRIO_DEFAULT, vid_tri: 2'b01};
   logic tick, fail;
   ssfs_stat_t stat;
   int n_fail = 0, checks_done = 0, n_drop = 0, n_tick;
   always #5 clk = ~clk;
   always @(posedge clk) n_drop <= n_drop + (fail === 1'b1);
   // Video 1 at twice the rate, divided by two in tri-level mode
   ssfs_sync_gen #(.PER('{10, 20, 21, 20})) ssfs_sync_gen_inst (.clk_i(clk),
      .en_i(en), .sync_o(sync));
   ssfs_selector #(.VID_TRI_DIV(16'h0002), .WIN_NOM(24'h005000),
      .WIN_TOL(24'h000032), .LOSS_LIM(24'h00002D)) ssfs_selector_inst (
      .clk_i(clk), .reset_i(rst), .sync_i(sync), .router_active_i(act),
      .cfg_i(cfg), .tick48_o(tick), .fail_o(fail), .stat_o(stat));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_src(input logic [2:0] s, input int lim);
      int i = 0;
      while (!(stat.locked === 1'b1 && stat.src === s) && i++ < lim)
         @(posedge clk);
      if (i > lim) begin
         n_fail++;
         end_of_test();
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 5; r++) begin
         @(posedge clk);
         en <= rows[r].en;
         cfg.prio <= rows[r].prio;
         wait_src(rows[r].src, r == 0 ? 45000 : 300);
         repeat (3) @(posedge clk);
         check(stat.rank, rows[r].rank);
         check(stat.src, rows[r].src);
         n_tick = 0;
         repeat (200) @(posedge clk) n_tick += (tick === 1'b1);
         if (r < 4) check(n_tick, 10);
      end
      check(n_drop, 3);
      act <= 1'b0;
      repeat (10) @(posedge clk);
      check(stat.locked, 1'b0);
      check(n_drop, 4);
      act <= 1'b1;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      check({stat.locked, stat.src, tick, fail}, {1'b0, SRC_INT, 2'b00});
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check(stat.avail[3:0], 4'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
